/* hdl/tcmc_pkg.sv */
/*
 * constants for the timer channel mode and configuration block:
 * register addresses, field positions, reset values, channel-5 input codes.
 * assumes a 20-bit cpu address space with 16-bit data.
 */
`default_nettype none
package tcmc_pkg;
    localparam int NUM_CH = 8;
    localparam logic [19:0] MODE_BASE_ADDR = 20'hf0190;
    localparam logic [19:0] MODE_LAST_ADDR = 20'hf019e;
    localparam logic [19:0] ISEL_ADDR = 20'hf0074;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [7:0] ISEL_RESET = 8'h00;
    localparam int OPCLK_HI_POS = 15;
    localparam int OPCLK_LO_POS = 14;
    localparam int SRC_BIT_POS = 12;
    localparam int LEAD_BIT_POS = 11;
    localparam int EDGE_HI_POS = 7;
    localparam int EDGE_LO_POS = 6;
    localparam logic [15:0] MODE_KEEP_MASK = 16'hdfcf;
    localparam logic [15:0] LEAD_BIT_MASK = 16'h0800;
    localparam logic [7:0] ISEL_KEEP_MASK = 8'h07;
    localparam logic [2:0] ISEL_LOW_OSC = 3'h4;
    localparam logic [2:0] ISEL_SUB_CLK = 3'h5;
    localparam logic [1:0] OPCLK_ZERO = 2'h0;
    localparam logic [1:0] OPCLK_TWO = 2'h1;
    localparam logic [1:0] OPCLK_ONE = 2'h2;
    localparam logic [1:0] OPCLK_THREE = 2'h3;
    localparam int CH_FIVE = 5;
    localparam int CH_SEVEN = 7;
endpackage
`default_nettype wire

/* hdl/tcmc_top.sv */
/*
 * eight channel mode registers and the channel-5 input select register,
 * operation clock and count clock selection, edge detection, output level.
 * assumes prescaled clock enables come from logic on ref_clk_in; timer
 * input pins and the low-speed and subsystem clocks are asynchronous.
 */
`default_nettype none
// How it works
// R1 - bits 15:14 pick prescaled clock: 00 zero, 01 two, 10 one, 11 three
// R2 - software uses clocks two and three only on channels 1 and 3
// R3 - bit 12 low: operation clock counts; high: timer input valid edge counts
// R4 - selected operation clock samples the edge detector; count clock follows bit 12
// R5 - count clock enable drives counter, output control and interrupt logic
// R6 - bit 11 is lead on 2,4,6, split on 1,3, zero elsewhere
// R7 - software writes zero to bits 13, 5 and 4
// R8 - eight 16-bit mode registers from f0190 to f019e, reset 0000
// R9 - one unit with channels 0 to 7, each with its own mode register
// R10 - software stops all channels before changing the system clock source
// R11 - channel-5 codes 0-3 pin, 4 low-speed oscillator, 5 subsystem clock
// R12 - channel-5 select at f0074, bits 2:0, upper bits read zero, reset 00
// R13 - software writes the channel-5 select register with byte writes
// R14 - software keeps top select bit clear while cpu runs from subsystem clock
// R15 - interrupt-driven output change colliding with a software write still lands
// R16 - start, edge and mode fields are stored and passed through unchanged
module tcmc_top (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [19:0] cpu_addr_in,
    input wire logic [15:0] cpu_wdata_in,
    input wire logic [1:0] cpu_be_in,
    input wire logic cpu_wr_in,
    input wire logic cpu_rd_in,
    output logic [15:0] cpu_rdata_out,
    input wire logic [3:0] prescaled_clock_in,
    input wire logic [tcmc_pkg::NUM_CH-1:0] channel_timer_input_pin_in,
    input wire logic ch7_input_switch_in,
    input wire logic low_speed_osc_clock_in,
    input wire logic subsystem_clock_in,
    input wire logic [tcmc_pkg::NUM_CH-1:0] timer_output_enable_bit_in,
    input wire logic [tcmc_pkg::NUM_CH-1:0] out_level_wr_in,
    input wire logic [tcmc_pkg::NUM_CH-1:0] out_level_wdata_in,
    input wire logic [tcmc_pkg::NUM_CH-1:0] channel_timer_interrupt_in,
    output logic [tcmc_pkg::NUM_CH-1:0] op_clock_en_out,
    output logic [tcmc_pkg::NUM_CH-1:0] count_clock_en_out,
    output logic [tcmc_pkg::NUM_CH-1:0] timer_output_pin_out,
    output logic [tcmc_pkg::NUM_CH*16-1:0] mode_fields_out
);
    import tcmc_pkg::*;

    function automatic logic [15:0] keep_mask(input int ch);
        if (ch == 0 || ch == CH_FIVE || ch == CH_SEVEN) begin
            keep_mask = MODE_KEEP_MASK & ~LEAD_BIT_MASK;
        end else begin
            keep_mask = MODE_KEEP_MASK;
        end
    endfunction

    function automatic logic pick_clock(input logic [1:0] code, input logic [3:0] ck);
        case (code)
            OPCLK_ZERO: pick_clock = ck[0];
            OPCLK_TWO: pick_clock = ck[2];
            OPCLK_ONE: pick_clock = ck[1];
            OPCLK_THREE: pick_clock = ck[3];
            default: pick_clock = ck[0];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [15:0] mode [NUM_CH];
    logic [15:0] next_mode [NUM_CH];
    logic [7:0] isel;
    logic [7:0] next_isel;
    logic [15:0] next_rdata;
    logic mode_hit;
    logic [2:0] mode_idx;

    always_comb begin
        mode_hit = (cpu_addr_in >= MODE_BASE_ADDR) && (cpu_addr_in <= (MODE_LAST_ADDR | 20'h1));
        mode_idx = 3'((cpu_addr_in - MODE_BASE_ADDR) >> 1);
        next_isel = isel;
        next_rdata = 16'h0000;
        for (int n = 0; n < NUM_CH; n++) begin
            next_mode[n] = mode[n];
            if (cpu_wr_in && mode_hit && mode_idx == 3'(n)) begin
                if (cpu_be_in[0]) begin
                    next_mode[n][7:0] = 8'(cpu_wdata_in & keep_mask(n)); // [R7] [R16]
                end
                if (cpu_be_in[1]) begin
                    next_mode[n][15:8] = 8'((cpu_wdata_in & keep_mask(n)) >> 8); // [R6]
                end
            end
        end
        if (cpu_wr_in && cpu_be_in[0] && cpu_addr_in[19:1] == ISEL_ADDR[19:1]) begin
            next_isel = cpu_wdata_in[7:0] & ISEL_KEEP_MASK; // [R12] [R13]
        end
        if (cpu_rd_in && mode_hit) begin
            next_rdata = mode[mode_idx]; // [R8] [R9]
        end else if (cpu_rd_in && cpu_addr_in[19:1] == ISEL_ADDR[19:1]) begin
            next_rdata = {8'h00, isel}; // [R12]
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int n = 0; n < NUM_CH; n++) begin
                mode[n] <= MODE_RESET; // [R8]
            end
            isel <= ISEL_RESET;
            cpu_rdata_out <= 16'h0000;
        end else begin
            for (int n = 0; n < NUM_CH; n++) begin
                mode[n] <= next_mode[n];
            end
            isel <= next_isel;
            cpu_rdata_out <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [NUM_CH+2:0] sync_a;
    logic [NUM_CH+2:0] sync_b;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {subsystem_clock_in, low_speed_osc_clock_in, ch7_input_switch_in,
                       channel_timer_input_pin_in};
            sync_b <= sync_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel clock selection, edge detection and output level
    logic [NUM_CH-1:0] chan_in;
    logic [NUM_CH-1:0] op_sel;
    logic [NUM_CH-1:0] edge_seen;
    logic [NUM_CH-1:0] last_in;
    logic [NUM_CH-1:0] next_last_in;
    logic [NUM_CH-1:0] next_op_en;
    logic [NUM_CH-1:0] next_cnt_en;
    logic [NUM_CH-1:0] next_tout;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            if (g == CH_FIVE) begin : g_five
                always_comb begin
                    if (isel[2:0] == ISEL_LOW_OSC) begin
                        chan_in[g] = sync_b[NUM_CH+1]; // [R11]
                    end else if (isel[2:0] == ISEL_SUB_CLK) begin
                        chan_in[g] = sync_b[NUM_CH+2]; // [R11]
                    end else begin
                        chan_in[g] = sync_b[g]; // [R11]
                    end
                end
            end else if (g == CH_SEVEN) begin : g_seven
                assign chan_in[g] = sync_b[NUM_CH]; // [R3]
            end else begin : g_pin
                assign chan_in[g] = sync_b[g];
            end

            always_comb begin
                op_sel[g] = pick_clock(mode[g][OPCLK_HI_POS:OPCLK_LO_POS],
                        prescaled_clock_in); // [R1]
                next_last_in[g] = op_sel[g] ? chan_in[g] : last_in[g]; // [R4]
                case (mode[g][EDGE_HI_POS:EDGE_LO_POS])
                    2'h0: edge_seen[g] = last_in[g] & ~chan_in[g];
                    2'h1: edge_seen[g] = ~last_in[g] & chan_in[g];
                    default: edge_seen[g] = last_in[g] ^ chan_in[g];
                endcase
                next_op_en[g] = op_sel[g];
                next_cnt_en[g] = mode[g][SRC_BIT_POS] ? (op_sel[g] & edge_seen[g])
                        : op_sel[g]; // [R3] [R5]
                next_tout[g] = out_level_wr_in[g] ? out_level_wdata_in[g] : timer_output_pin_out[g];
                if (timer_output_enable_bit_in[g] && channel_timer_interrupt_in[g]) begin
                    next_tout[g] = ~next_tout[g]; // [R15]
                end
            end
            assign mode_fields_out[g*16 +: 16] = mode[g]; // [R16]
        end
    endgenerate

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            last_in <= '0;
            op_clock_en_out <= '0;
            count_clock_en_out <= '0;
            timer_output_pin_out <= '0;
        end else begin
            last_in <= next_last_in;
            op_clock_en_out <= next_op_en;
            count_clock_en_out <= next_cnt_en;
            timer_output_pin_out <= next_tout;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_lead_zero;
        @(posedge ref_clk_in) disable iff (rst_in)
        mode[0][LEAD_BIT_POS] == 1'b0 && mode[CH_FIVE][LEAD_BIT_POS] == 1'b0
            && mode[CH_SEVEN][LEAD_BIT_POS] == 1'b0;
    endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("bit 11 set on 0, 5 or 7"); // [R6]

    property p_lead_kept;
        @(posedge ref_clk_in) disable iff (rst_in)
        cpu_wr_in && cpu_be_in[1] && cpu_addr_in == MODE_BASE_ADDR + 20'h4 && cpu_wdata_in[11]
            |=> mode[2][LEAD_BIT_POS];
    endproperty
    a_lead_kept: assert property (p_lead_kept) else $error("lead bit not stored"); // [R6]

    property p_zero_bits;
        @(posedge ref_clk_in) disable iff (rst_in)
        (mode[3] & ~MODE_KEEP_MASK) == 16'h0000;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("bits 13, 5 or 4 set"); // [R7]

    property p_opclk_map;
        @(posedge ref_clk_in) disable iff (rst_in)
        mode[1][OPCLK_HI_POS:OPCLK_LO_POS] == OPCLK_TWO
            |=> op_clock_en_out[1] == $past(prescaled_clock_in[2]);
    endproperty
    a_opclk_map: assert property (p_opclk_map) else $error("wrong prescaled clock"); // [R1]

    property p_cnt_src;
        @(posedge ref_clk_in) disable iff (rst_in)
        !mode[0][SRC_BIT_POS] |=> count_clock_en_out[0] == op_clock_en_out[0];
    endproperty
    a_cnt_src: assert property (p_cnt_src) else $error("count clock not operation clock"); // [R3]

    property p_cnt_edge;
        @(posedge ref_clk_in) disable iff (rst_in)
        count_clock_en_out[4] && $past(mode[4][SRC_BIT_POS]) |-> op_clock_en_out[4];
    endproperty
    a_cnt_edge: assert property (p_cnt_edge) else $error("edge count off operation clock"); // [R4]

    property p_isel_upper;
        @(posedge ref_clk_in) disable iff (rst_in)
        cpu_rd_in && cpu_addr_in == ISEL_ADDR |=> cpu_rdata_out[15:3] == 13'h0000;
    endproperty
    a_isel_upper: assert property (p_isel_upper) else $error("select upper bits not zero"); // [R12]

    property p_mode_write;
        @(posedge ref_clk_in) disable iff (rst_in)
        cpu_wr_in && cpu_be_in == 2'h3 && cpu_addr_in == MODE_BASE_ADDR + 20'h6
            |=> mode[3] == ($past(cpu_wdata_in) & MODE_KEEP_MASK);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // [R8]

    property p_out_collide;
        @(posedge ref_clk_in) disable iff (rst_in)
        out_level_wr_in[0] && timer_output_enable_bit_in[0] && channel_timer_interrupt_in[0]
            |=> timer_output_pin_out[0] == !$past(out_level_wdata_in[0]);
    endproperty
    a_out_collide: assert property (p_out_collide) else $error("output collision lost"); // [R15]

    property p_opclk_three;
        @(posedge ref_clk_in) disable iff (rst_in)
        mode[3][OPCLK_HI_POS:OPCLK_LO_POS] == OPCLK_THREE
            |=> op_clock_en_out[3] == $past(prescaled_clock_in[3]);
    endproperty
    a_opclk_three: assert property (p_opclk_three) else $error("clock three not used"); // [R1]

    property p_cnt_gated;
        @(posedge ref_clk_in) disable iff (rst_in)
        (count_clock_en_out & ~op_clock_en_out) == '0;
    endproperty
    a_cnt_gated: assert property (p_cnt_gated) else $error("count outside op clock"); // [R4]

    property p_isel_write;
        @(posedge ref_clk_in) disable iff (rst_in)
        cpu_wr_in && cpu_be_in[0] && cpu_addr_in == ISEL_ADDR
            |=> isel == ($past(cpu_wdata_in[7:0]) & ISEL_KEEP_MASK);
    endproperty
    a_isel_write: assert property (p_isel_write) else $error("select write lost"); // [R12]

    property p_ch7_route;
        @(posedge ref_clk_in) disable iff (rst_in)
        mode[CH_SEVEN][SRC_BIT_POS] && mode[CH_SEVEN][EDGE_HI_POS:EDGE_LO_POS] == 2'h1
            && op_sel[CH_SEVEN] && !last_in[CH_SEVEN] && sync_b[NUM_CH]
            |=> count_clock_en_out[CH_SEVEN];
    endproperty
    a_ch7_route: assert property (p_ch7_route) else $error("switch edge lost on 7"); // [R3]

    property p_ch5_route;
        @(posedge ref_clk_in) disable iff (rst_in)
        mode[CH_FIVE][SRC_BIT_POS] && mode[CH_FIVE][EDGE_HI_POS:EDGE_LO_POS] == 2'h1
            && isel[2:0] == ISEL_LOW_OSC && op_sel[CH_FIVE] && !last_in[CH_FIVE]
            && sync_b[NUM_CH+1] |=> count_clock_en_out[CH_FIVE];
    endproperty
    a_ch5_route: assert property (p_ch5_route) else $error("osc edge lost on 5"); // [R11]

    property p_out_hold;
        @(posedge ref_clk_in) disable iff (rst_in)
        out_level_wr_in == '0 && channel_timer_interrupt_in == '0
            |=> $stable(timer_output_pin_out);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output level moved by itself"); // [R15]

    c_split_clk3: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        mode[3][OPCLK_HI_POS:OPCLK_LO_POS] == OPCLK_THREE && count_clock_en_out[3]);
    c_ch5_sub: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        isel[2:0] == ISEL_SUB_CLK && count_clock_en_out[CH_FIVE]);
    c_collide: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        out_level_wr_in[2] && channel_timer_interrupt_in[2] && timer_output_enable_bit_in[2]);
    c_edge_both: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        mode[CH_FIVE][EDGE_HI_POS] && count_clock_en_out[CH_FIVE]);
    c_fall_ch7: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        mode[CH_SEVEN][EDGE_HI_POS:EDGE_LO_POS] == 2'h0 && count_clock_en_out[CH_SEVEN]);
endmodule
`default_nettype wire

/* sim/test_timer_channel_mode_config.sv */
/*
 * self-checking bench for the timer channel mode and configuration block.
 * assumes tcmc_pkg and tcmc_top are compiled ahead of this file.
 */
`default_nettype none
`define TCMC_CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
////////////////////////////////////////////////////////////////////////////////
module test_timer_channel_mode_config;
    timeunit 1ns;
    timeprecision 100ps;
    import tcmc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [19:0] addr = '0;
    logic [15:0] wdata = '0;
    logic [1:0] be = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] pclk = '0;
    logic [3:0] src = '0;
    logic [7:0] oen = '0;
    logic [7:0] owr = '0;
    logic [7:0] owd = '0;
    logic [7:0] irq = '0;
    logic [15:0] rdata;
    logic [7:0] op_en;
    logic [7:0] cnt_en;
    logic [7:0] tpin;
    logic [127:0] fields;
    logic [15:0] mode_m [8];
    logic [15:0] v;
    logic [31:0] rnd;
    logic [7:0] pin_m = '0;
    int failures = 0;
    int tests_run = 0;
    int found;
    int clk_map [4] = '{0, 2, 1, 3};
    int ch_of [4] = '{5, 5, 5, 7};
    int sel_code [4] = '{0, 4, 5, 0};
////////////////////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;
    tcmc_top dut (
        .ref_clk_in(clk), .rst_in(rst), .cpu_addr_in(addr), .cpu_wdata_in(wdata),
        .cpu_be_in(be), .cpu_wr_in(wr), .cpu_rd_in(rd), .cpu_rdata_out(rdata),
        .prescaled_clock_in(pclk), .channel_timer_input_pin_in({2'b00, src[0], 5'h00}),
        .ch7_input_switch_in(src[3]), .low_speed_osc_clock_in(src[1]),
        .subsystem_clock_in(src[2]), .timer_output_enable_bit_in(oen),
        .out_level_wr_in(owr), .out_level_wdata_in(owd), .channel_timer_interrupt_in(irq),
        .op_clock_en_out(op_en), .count_clock_en_out(cnt_en),
        .timer_output_pin_out(tpin), .mode_fields_out(fields)
    );
////////////////////////////////////////////////////////////////////////////////
    task automatic bus_write(input logic [19:0] a, input logic [15:0] d, input logic [1:0] b);
        @(negedge clk);
        addr = a;
        wdata = d;
        be = b;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic bus_read(input logic [19:0] a, output logic [15:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask
    function automatic logic [15:0] mode_exp(input int n, input logic [15:0] d);
        logic [15:0] r;
        r = d & MODE_KEEP_MASK;
        if (n == 0 || n == 5 || n == 7) begin
            r = r & ~LEAD_BIT_MASK;
        end
        return r;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(77));
        // the system clock source stays fixed, so no channel stop is needed
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int n = 0; n < 8; n++) begin
            bus_read(MODE_BASE_ADDR + 20'(2 * n), v);
            `TCMC_CHK(v, MODE_RESET)
        end
        bus_read(ISEL_ADDR, v);
        `TCMC_CHK(v, {8'h00, ISEL_RESET})
        // random mode values, fixed-zero bits left clear by software
        for (int n = 0; n < 8; n++) begin
            rnd = $urandom() & 32'h0000dfcf;
            if (n != 1 && n != 3) rnd[14] = 1'b0;
            bus_write(MODE_BASE_ADDR + 20'(2 * n), rnd[15:0], 2'h3);
            mode_m[n] = mode_exp(n, rnd[15:0]);
        end
        bus_write(MODE_BASE_ADDR + 20'h6, 16'hdf00, 2'h2);
        mode_m[3] = mode_exp(3, {8'hdf, mode_m[3][7:0]});
        for (int n = 0; n < 8; n++) begin
            bus_read(MODE_BASE_ADDR + 20'(2 * n), v);
            `TCMC_CHK(v, mode_m[n])
            `TCMC_CHK(fields[16 * n +: 16], mode_m[n])
        end
        rnd = $urandom();
        bus_write(ISEL_ADDR, {8'h00, rnd[7:0]}, 2'h1);
        bus_read(ISEL_ADDR, v);
        `TCMC_CHK(v, {8'h00, rnd[7:0] & ISEL_KEEP_MASK})
        bus_read(20'hf0080, v);
        `TCMC_CHK(v, 16'h0000)
        // input-edge counting on channels 5 and 7, rising edge field
        bus_write(MODE_BASE_ADDR + 20'ha, 16'h1040, 2'h3);
        bus_write(MODE_BASE_ADDR + 20'he, 16'h1040, 2'h3);
        pclk = 4'h1;
        for (int k = 0; k < 4; k++) begin
            src = '0;
            if (k < 3) bus_write(ISEL_ADDR, 16'(sel_code[k]), 2'h1);
            repeat (4) @(negedge clk);
            src = 4'(1 << ((k + 1) % 4));
            found = 0;
            repeat (5) begin
                @(negedge clk);
                if (cnt_en[ch_of[k]] !== 1'b0) found++;
            end
            `TCMC_CHK(found, 0)
            src = src | 4'(1 << k);
            for (int c = 0; c < 8 && found == 0; c++) begin
                @(negedge clk);
                if (cnt_en[ch_of[k]] === 1'b1) found = 1;
            end
            `TCMC_CHK(found, 1)
            if (found == 0) tally_and_finish();
        end
        // falling-edge field on channel 7, both-edges field on channel 5
        bus_write(MODE_BASE_ADDR + 20'he, 16'h1000, 2'h3);
        bus_write(MODE_BASE_ADDR + 20'ha, 16'h1080, 2'h3);
        repeat (4) @(negedge clk);
        src = 4'h4;
        found = 0;
        for (int c = 0; c < 8 && found != 3; c++) begin
            @(negedge clk);
            if (cnt_en[CH_SEVEN] === 1'b1) found = found | 1;
            if (cnt_en[CH_FIVE] === 1'b1) found = found | 2;
        end
        `TCMC_CHK(found, 3)
        pclk = '0;
        src = '0;
        // operation clock codes on channel 1, counting the operation clock
        for (int code = 0; code < 4; code++) begin
            bus_write(MODE_BASE_ADDR + 20'h2, 16'(code << 14), 2'h3);
            for (int idx = 0; idx < 4; idx++) begin
                @(negedge clk);
                pclk = 4'(1 << idx);
                @(negedge clk);
                pclk = '0;
                `TCMC_CHK(op_en[1], 1'(idx == clk_map[code]))
                `TCMC_CHK(cnt_en[1], 1'(idx == clk_map[code]))
            end
        end
        // random output writes colliding with interrupt toggles
        for (int k = 0; k < 24; k++) begin
            @(negedge clk);
            `TCMC_CHK(tpin, pin_m)
            {owr, owd, oen, irq} = $urandom();
            pin_m = ((owr & owd) | (~owr & pin_m)) ^ (oen & irq);
        end
        @(negedge clk);
        {owr, irq} = '0;
        `TCMC_CHK(tpin, pin_m)
        // reset in mid-run clears registers and outputs
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        `TCMC_CHK(tpin, 8'h00)
        bus_read(MODE_BASE_ADDR + 20'h6, v);
        `TCMC_CHK(v, MODE_RESET)
        tally_and_finish();
    end
endmodule
`default_nettype wire
